// file: hdl/translation_query.sv
// Purpose: Software driven address translation query unit with APB access.
// Assumes: Stream entry and walk outcome are supplied by software registers.
// Notes: A query takes a check cycle and then a fixed walk time.

// Notes on behaviour
// - Stage 2 query rejected on vm port, no stage 2
// - Stage 2 query, stage 2 not configured: invalid stage
// - No secure stage 2: secure stage 2 query invalid
// - Stage 2 query with substream valid: invalid request
// - Nested query rejected on vm port or missing stage
// - Nested query, either stage not configured: invalid stage
// - Stage 1 stage check uses config field only
// - Illegal query for the port gives invalid request
// - Invalid stream entry gives bad stream entry error
// - Global port, config 0xx or 100: invalid stage
// - Vm port, config 0xx or 100: bad entry
// - Bypassed stage 1 returns input address untranslated
// - Nested bypass translates input address at stage 2
// - Access properties come only from query address
// - Non-secure attribute comes only from query address
// - Success clears fault, returns address and attributes
// - Device memory always reports outer shareable
// - Attributes exclude stream entry overrides
// - Failure sets fault bit and loads code
// - Failure reports reason; faulting address only for stage 2 input faults
// - Fault codes grouped translation related or miscellaneous
// - Run clears on the same edge that writes the result
// - Only stage 1 type accepted from vm port
module translation_query (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import tq_pkg::*;

   // ****************************************
   // Register state
   // ****************************************
   state_t state_r, state_nxt;
   logic run_r, run_nxt;
   logic [31:0] sid_r, sid_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [31:0] cfg_r, cfg_nxt;
   logic [31:0] ste_r, ste_nxt;
   result_t res_r, res_nxt;
   logic [31:0] faulting_ipa_r, faulting_ipa_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;

   ste_t stream_table_entry;
   logic [1:0] qtype;
   logic on_vm, s1_impl, s2_impl, secure_stage2_capable, secif, secure_stream_select, ssv;
   logic s1_cfg, s2_cfg, cfg_low;
   logic [7:0] check_code;
   logic access, wr_ok, mapped;
   logic [3:0] q_props;

   assign stream_table_entry = ste_t'(ste_r[15:0]);
   assign qtype = addr_r[ADDR_TYPE_LSB +: 2];
   assign on_vm = cfg_r[CFG_VM_BIT];
   assign s1_impl = cfg_r[CFG_S1_BIT];
   assign s2_impl = cfg_r[CFG_S2_BIT];
   assign secure_stage2_capable = cfg_r[CFG_SECURE_STAGE2_CAPABLE_BIT];
   assign secif = cfg_r[CFG_SECIF_BIT];
   assign secure_stream_select = sid_r[SID_SECURE_STREAM_SELECT_BIT];
   assign ssv = sid_r[SID_SSV_BIT];
   // Access properties are taken from the query word alone; the entry holds no overrides.
   assign q_props = {addr_r[ADDR_NS_BIT], addr_r[ADDR_PNU_BIT], addr_r[ADDR_IND_BIT],
      addr_r[ADDR_RNW_BIT]};
   // Only the three-bit config field decides stage enables, never the substream default.
   assign s1_cfg = (stream_table_entry.config_f == CFG_S1_TRANS) || (stream_table_entry.config_f == CFG_BOTH);
   assign s2_cfg = (stream_table_entry.config_f == CFG_S2_TRANS) || (stream_table_entry.config_f == CFG_BOTH);
   assign cfg_low = !stream_table_entry.config_f[2] || (stream_table_entry.config_f == 3'b100);

   // ****************************************
   // Invocation checks
   // ****************************************
   always_comb begin
      check_code = FC_NONE;
      unique case (qtype)
         TYPE_S1: begin
            if (!s1_impl) begin
               check_code = FC_INVALID_REQUEST_ERROR;
            end
         end
         TYPE_S2: begin
            if (on_vm || !s2_impl || ssv) begin
               check_code = FC_INVALID_REQUEST_ERROR;
            end else if (secif && secure_stream_select && !secure_stage2_capable) begin
               check_code = FC_INVALID_STAGE_ERROR;
            end
         end
         TYPE_NEST: begin
            if (on_vm || !s1_impl || !s2_impl) begin
               check_code = FC_INVALID_REQUEST_ERROR;
            end else if (secif && secure_stream_select && !secure_stage2_capable) begin
               check_code = FC_INVALID_STAGE_ERROR;
            end
         end
         default: begin
            check_code = FC_INVALID_REQUEST_ERROR;
         end
      endcase
   end

   // ****************************************
   // Query sequencer
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      run_nxt = run_r;
      res_nxt = res_r;
      faulting_ipa_nxt = faulting_ipa_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         ST_IDLE: begin
            if (run_r) begin
               state_nxt = ST_CHECK;
            end
         end
         ST_CHECK: begin
            res_nxt = '0;
            faulting_ipa_nxt = '0;
            res_nxt.fault = 1'b1;
            res_nxt.reason = RSN_S1;
            // Invocation errors are decided before the entry is looked at.
            if (check_code != FC_NONE) begin
               res_nxt.code = check_code;
               state_nxt = ST_IDLE;
               run_nxt = 1'b0;
            end else if (!stream_table_entry.valid) begin
               res_nxt.code = FC_BAD_STE;
               state_nxt = ST_IDLE;
               run_nxt = 1'b0;
            end else if (cfg_low) begin
               res_nxt.code = on_vm ? FC_BAD_STE : FC_INVALID_STAGE_ERROR;
               state_nxt = ST_IDLE;
               run_nxt = 1'b0;
            end else if ((qtype == TYPE_S1 && !s1_cfg) || (qtype == TYPE_S2 && !s2_cfg)
                  || (qtype == TYPE_NEST && !(s1_cfg && s2_cfg))) begin
               res_nxt.code = FC_INVALID_STAGE_ERROR;
               state_nxt = ST_IDLE;
               run_nxt = 1'b0;
            end else begin
               cnt_nxt = WALK_CYCLES;
               state_nxt = ST_WALK;
            end
         end
         ST_WALK: begin
            if (!cfg_r[CFG_EN_BIT]) begin
               res_nxt.fault = 1'b1;
               res_nxt.code = FC_INTERNAL;
               state_nxt = ST_IDLE;
               run_nxt = 1'b0;
            end else if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               state_nxt = ST_IDLE;
               run_nxt = 1'b0;
               if (stream_table_entry.walk_fault) begin
                  res_nxt.fault = 1'b1;
                  res_nxt.code = FC_TRANSLATION;
                  // Stage 2 faults on the incoming address report it as faulting.
                  if (qtype == TYPE_S2 || (qtype == TYPE_NEST && !ssv
                        && stream_table_entry.dss == DSS_BYPASS)) begin
                     res_nxt.reason = RSN_S2_IN;
                     faulting_ipa_nxt = {addr_r[31:ADDR_PAGE_LSB], 12'h000};
                  end else begin
                     res_nxt.reason = RSN_S1;
                  end
               end else begin
                  res_nxt.fault = 1'b0;
                  res_nxt.code = FC_NONE;
                  // Bypassed stage 1 returns the input page unchanged.
                  res_nxt.page = addr_r[31:ADDR_PAGE_LSB];
                  res_nxt.attr = stream_table_entry.attr;
                  res_nxt.sh = stream_table_entry.device ? SH_OUTER : stream_table_entry.attr[1:0];
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Software can only set run; the sequencer clears it.
      if (access && pwrite && wr_ok && paddr == OFF_CTRL && pwdata[CTRL_RUN_BIT]) begin
         run_nxt = 1'b1;
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   assign access = psel && penable && !pready_r;
   // Writes to the query group are ignored while a query runs.
   assign wr_ok = !run_r;
   assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_SID) || (paddr == OFF_ADDR)
      || (paddr == OFF_RESULT) || (paddr == OFF_FAULTING_IPA) || (paddr == OFF_CFG)
      || (paddr == OFF_STE) || (paddr == OFF_WALK);

   always_comb begin
      sid_nxt = sid_r;
      addr_nxt = addr_r;
      cfg_nxt = cfg_r;
      ste_nxt = ste_r;
      prdata_nxt = prdata_r;
      pready_nxt = access;
      pslverr_nxt = access && !mapped;
      if (access && pwrite && wr_ok) begin
         unique case (paddr)
            OFF_SID: sid_nxt = pwdata;
            OFF_ADDR: addr_nxt = pwdata;
            OFF_CFG: cfg_nxt = pwdata;
            OFF_STE: ste_nxt = pwdata;
            default: ;
         endcase
      end
      if (access && !pwrite) begin
         unique case (paddr)
            OFF_CTRL: prdata_nxt = {31'h0000_0000, run_r};
            OFF_SID: prdata_nxt = sid_r;
            OFF_ADDR: prdata_nxt = addr_r;
            OFF_RESULT: prdata_nxt = {res_r.page, res_r.attr, res_r.sh, res_r.reason};
            OFF_FAULTING_IPA: prdata_nxt = {res_r.code, 19'h0_0000, q_props, res_r.fault};
            OFF_CFG: prdata_nxt = cfg_r;
            OFF_STE: prdata_nxt = ste_r;
            OFF_WALK: prdata_nxt = faulting_ipa_r;
            default: prdata_nxt = RST_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         run_r <= 1'b0;
         sid_r <= RST_WORD;
         addr_r <= RST_WORD;
         cfg_r <= RST_CFG;
         ste_r <= RST_WORD;
         res_r <= '0;
         faulting_ipa_r <= RST_WORD;
         cnt_r <= 4'h0;
         prdata_r <= RST_WORD;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         run_r <= run_nxt;
         sid_r <= sid_nxt;
         addr_r <= addr_nxt;
         cfg_r <= cfg_nxt;
         ste_r <= ste_nxt;
         res_r <= res_nxt;
         faulting_ipa_r <= faulting_ipa_nxt;
         cnt_r <= cnt_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ****************************************
   // Checks
   // ****************************************
   AST_VM_S2_REQ: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_CHECK && qtype == TYPE_S2 && on_vm) |=> (res_r.code == FC_INVALID_REQUEST_ERROR
      && !run_r)) else $error("stage 2 query on vm port not rejected");
   AST_SSV_S2: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_CHECK && qtype == TYPE_S2 && ssv) |=> res_r.code == FC_INVALID_REQUEST_ERROR)
      else $error("stage 2 query with substream not rejected");
   AST_NEST_REQ: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_CHECK && qtype == TYPE_NEST && (!s1_impl || !s2_impl))
      |=> res_r.code == FC_INVALID_REQUEST_ERROR) else $error("nested query not rejected");
   AST_BAD_STE: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_CHECK && check_code == FC_NONE && !stream_table_entry.valid)
      |=> res_r.code == FC_BAD_STE) else $error("bad entry not reported");
   AST_VM_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_CHECK && check_code == FC_NONE && stream_table_entry.valid && cfg_low && on_vm)
      |=> res_r.code == FC_BAD_STE) else $error("vm low config not bad entry");
   AST_RUN_DONE: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(run_r) |-> state_r == ST_IDLE && $past(state_r) != ST_IDLE)
      else $error("run cleared without result");
   AST_DEVICE_SH: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_WALK && cnt_r == 4'h0 && cfg_r[CFG_EN_BIT] && !stream_table_entry.walk_fault
      && stream_table_entry.device) |=> res_r.sh == SH_OUTER && !res_r.fault)
      else $error("device memory not outer shareable");
   AST_WALK_TIME: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_CHECK && state_nxt == ST_WALK && cfg_r[CFG_EN_BIT])
      |=> state_r == ST_WALK [*5] ##1 !run_r) else $error("walk length wrong");
endmodule

// file: shared/tq_pkg.sv
// Purpose: Shared constants and types for the translation query unit.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Fault codes and register offsets are local encodings.
package tq_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_SID = 12'h004;
   localparam logic [11:0] OFF_ADDR = 12'h008;
   localparam logic [11:0] OFF_RESULT = 12'h00C;
   localparam logic [11:0] OFF_FAULTING_IPA = 12'h010;
   localparam logic [11:0] OFF_CFG = 12'h014;
   localparam logic [11:0] OFF_STE = 12'h018;
   localparam logic [11:0] OFF_WALK = 12'h01C;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_RUN_BIT = 0;
   localparam int SID_SSV_BIT = 31;
   localparam int SID_SECURE_STREAM_SELECT_BIT = 30;
   localparam int ADDR_TYPE_LSB = 0;
   localparam int ADDR_RNW_BIT = 4;
   localparam int ADDR_IND_BIT = 5;
   localparam int ADDR_PNU_BIT = 6;
   localparam int ADDR_NS_BIT = 7;
   localparam int ADDR_PAGE_LSB = 12;
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_S1_BIT = 1;
   localparam int CFG_S2_BIT = 2;
   localparam int CFG_SECURE_STAGE2_CAPABLE_BIT = 3;
   localparam int CFG_VM_BIT = 4;
   localparam int CFG_SECIF_BIT = 5;

   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] RST_CFG = 32'h0000_0007;
   localparam logic [3:0] WALK_CYCLES = 4'h4;

   // ****************************************
   // Encodings
   // ****************************************
   localparam logic [1:0] TYPE_S1 = 2'b01;
   localparam logic [1:0] TYPE_S2 = 2'b10;
   localparam logic [1:0] TYPE_NEST = 2'b11;
   localparam logic [1:0] DSS_BYPASS = 2'b01;
   localparam logic [2:0] CFG_S1_TRANS = 3'b101;
   localparam logic [2:0] CFG_S2_TRANS = 3'b110;
   localparam logic [2:0] CFG_BOTH = 3'b111;
   localparam logic [1:0] SH_OUTER = 2'b10;
   localparam logic [1:0] RSN_S1 = 2'b00;
   localparam logic [1:0] RSN_S2_IN = 2'b11;
   localparam logic [7:0] FC_NONE = 8'h00;
   localparam logic [7:0] FC_BAD_STE = 8'h04;
   localparam logic [7:0] FC_TRANSLATION = 8'h10;
   localparam logic [7:0] FC_INTERNAL = 8'hF0;
   localparam logic [7:0] FC_INVALID_REQUEST_ERROR = 8'hF1;
   localparam logic [7:0] FC_INVALID_STAGE_ERROR = 8'hF2;

   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_WALK} state_t;

   typedef struct packed {
      logic fault;
      logic [7:0] code;
      logic [1:0] reason;
      logic [1:0] sh;
      logic [7:0] attr;
      logic [19:0] page;
   } result_t;

   typedef struct packed {
      logic valid;
      logic [2:0] config_f;
      logic [1:0] dss;
      logic [7:0] attr;
      logic device;
      logic walk_fault;
   } ste_t;

endpackage

// file: testbench/translation_query_bench.sv
// Purpose: Self-checking bench for the translation query unit over APB.
// Assumes: One clock, asynchronous active-low reset, one wait state per APB access.
// Notes: Stream entry and walk outcome are loaded through the model registers.
module translation_query_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tq_pkg::*;

   // ****************************************
   // Signals and design
   // ****************************************
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int failures;
   int check_count;
   logic [31:0] st;
   logic [31:0] res;
   logic [31:0] wa;

   translation_query u_dut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   always #20 pclk = ~pclk;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic conclude();
      $display("Checks made %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Setup cycle, then access phase held until pready is seen at an edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1) begin
         failures++;
         conclude();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
   endtask

   function automatic logic [31:0] stream_table_entry(logic v, logic [2:0] c, logic [1:0] dss,
                                      logic [7:0] at, logic dev, logic wf);
      return {16'h0000, v, c, dss, at, dev, wf};
   endfunction

   // Polls run until the unit clears it; leaves status, result and address.
   task automatic wait_q();
      logic [31:0] q;
      int n;
      n = 0;
      rd(OFF_CTRL, q);
      while (q[CTRL_RUN_BIT] !== 1'b0 && n < 20) begin
         rd(OFF_CTRL, q);
         n++;
      end
      if (q[CTRL_RUN_BIT] !== 1'b0) begin
         failures++;
         conclude();
      end
      rd(OFF_FAULTING_IPA, st);
      rd(OFF_RESULT, res);
      rd(OFF_WALK, wa);
   endtask

   // Loads a query, starts it and waits for its result.
   task automatic run_q(input logic [31:0] cfg, input logic [31:0] sid,
                        input logic [31:0] addr, input logic [31:0] entry);
      wr(OFF_CFG, cfg);
      wr(OFF_SID, sid);
      wr(OFF_ADDR, addr);
      wr(OFF_STE, entry);
      wr(OFF_CTRL, 32'h0000_0001);
      wait_q();
   endtask

   task automatic inv(input logic [31:0] cfg, input logic [31:0] sid, input logic [1:0] typ,
                      input logic [31:0] entry, input logic [7:0] code);
      run_q(cfg, sid, {30'h0000_0000, typ}, entry);
      chk({31'h0000_0000, st[0]}, 32'h0000_0001);
      chk({24'h00_0000, st[31:24]}, {24'h00_0000, code});
      chk(wa, 32'h0000_0000);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic sc_reset();
      logic [31:0] q;
      logic e;
      rd(OFF_CFG, q);
      chk(q, RST_CFG);
      rd(OFF_CTRL, q);
      chk(q, RST_WORD);
      rd(OFF_RESULT, q);
      chk(q, RST_WORD);
      apb(1'b0, 12'h020, 32'h0000_0000, q, e);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      chk(q, 32'h0000_0000);
   endtask

   task automatic sc_invocation();
      logic [31:0] s1e;
      logic [31:0] s2e;
      logic [31:0] nse;
      logic [31:0] dse;
      logic [31:0] bad;
      logic [31:0] lo3;
      logic [31:0] lo4;
      logic [31:0] lo0;
      s1e = stream_table_entry(1'b1, CFG_S1_TRANS, 2'b00, 8'h00, 1'b0, 1'b0);
      s2e = stream_table_entry(1'b1, CFG_S2_TRANS, 2'b00, 8'h00, 1'b0, 1'b0);
      nse = stream_table_entry(1'b1, CFG_BOTH, 2'b00, 8'h00, 1'b0, 1'b0);
      dse = stream_table_entry(1'b1, CFG_S2_TRANS, DSS_BYPASS, 8'h00, 1'b0, 1'b0);
      bad = stream_table_entry(1'b0, CFG_S1_TRANS, 2'b00, 8'h00, 1'b0, 1'b0);
      lo3 = stream_table_entry(1'b1, 3'b011, 2'b00, 8'h00, 1'b0, 1'b0);
      lo4 = stream_table_entry(1'b1, 3'b100, 2'b00, 8'h00, 1'b0, 1'b0);
      lo0 = stream_table_entry(1'b1, 3'b000, 2'b00, 8'h00, 1'b0, 1'b0);
      inv(32'h0000_0007, 32'h0000_0000, 2'b00, s2e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0005, 32'h0000_0000, TYPE_S1, s1e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0017, 32'h0000_0000, TYPE_S2, s2e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0003, 32'h0000_0000, TYPE_S2, s2e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0007, 32'h0000_0000, TYPE_S2, s1e, FC_INVALID_STAGE_ERROR);
      inv(32'h0000_0027, 32'h4000_0000, TYPE_S2, s2e, FC_INVALID_STAGE_ERROR);
      inv(32'h0000_0027, 32'h4000_0000, TYPE_NEST, nse, FC_INVALID_STAGE_ERROR);
      inv(32'h0000_0007, 32'h8000_0000, TYPE_S2, s2e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0017, 32'h0000_0000, TYPE_NEST, s2e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0005, 32'h0000_0000, TYPE_NEST, s2e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0007, 32'h0000_0000, TYPE_NEST, s1e, FC_INVALID_STAGE_ERROR);
      inv(32'h0000_0007, 32'h0000_0000, TYPE_S1, dse, FC_INVALID_STAGE_ERROR);
      inv(32'h0000_0017, 32'h0000_0000, TYPE_NEST, s2e, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0007, 32'h0000_0000, TYPE_S1, bad, FC_BAD_STE);
      inv(32'h0000_0007, 32'h0000_0000, TYPE_S1, lo3, FC_INVALID_STAGE_ERROR);
      inv(32'h0000_0007, 32'h0000_0000, TYPE_S1, lo4, FC_INVALID_STAGE_ERROR);
      inv(32'h0000_0017, 32'h0000_0000, TYPE_S1, lo0, FC_BAD_STE);
      inv(32'h0000_0017, 32'h0000_0000, TYPE_S1, lo4, FC_BAD_STE);
      inv(32'h0000_0007, 32'h0000_0000, 2'b00, bad, FC_INVALID_REQUEST_ERROR);
      inv(32'h0000_0006, 32'h0000_0000, TYPE_S1, s1e, FC_INTERNAL);
   endtask

   task automatic sc_bypass();
      logic [31:0] q;
      logic [31:0] ok_e;
      ok_e = stream_table_entry(1'b1, CFG_S1_TRANS, DSS_BYPASS, 8'h5D, 1'b0, 1'b0);
      wr(OFF_CFG, 32'h0000_0007);
      wr(OFF_SID, 32'h0000_0000);
      wr(OFF_ADDR, 32'hABCD_E0A1);
      wr(OFF_STE, ok_e);
      wr(OFF_CTRL, 32'h0000_0001);
      // This write lands inside the walk, so it is ignored and the walk still succeeds.
      wr(OFF_STE, ok_e | 32'h0000_0001);
      wait_q();
      rd(OFF_STE, q);
      chk(q, ok_e);
      chk({23'h00_0000, st[31:24], st[0]}, {23'h00_0000, FC_NONE, 1'b0});
      chk({28'h000_0000, st[4:1]}, 32'h0000_000A);
      chk({12'h000, res[31:12]}, 32'h000A_BCDE);
      chk({24'h00_0000, res[11:4]}, 32'h0000_005D);
      chk({30'h0000_0000, res[3:2]}, 32'h0000_0001);
      wr(OFF_CTRL, 32'h0000_0001);
      rd(OFF_CTRL, q);
      chk({31'h0000_0000, q[CTRL_RUN_BIT]}, 32'h0000_0001);
      wait_q();
      chk({31'h0000_0000, st[0]}, 32'h0000_0000);
   endtask

   task automatic sc_device_and_fault();
      run_q(32'h0000_0007, 32'h0000_0000, 32'h1234_5053,
            stream_table_entry(1'b1, CFG_BOTH, 2'b00, 8'h01, 1'b1, 1'b0));
      chk({31'h0000_0000, st[0]}, 32'h0000_0000);
      chk({28'h000_0000, st[4:1]}, 32'h0000_0005);
      chk({30'h0000_0000, res[3:2]}, {30'h0000_0000, SH_OUTER});
      run_q(32'h0000_0007, 32'h0000_0000, 32'h1234_5001,
            stream_table_entry(1'b1, CFG_S1_TRANS, 2'b00, 8'h00, 1'b0, 1'b1));
      chk({23'h00_0000, st[31:24], st[0]}, {23'h00_0000, FC_TRANSLATION, 1'b1});
      chk({30'h0000_0000, res[1:0]}, {30'h0000_0000, RSN_S1});
      chk(wa, 32'h0000_0000);
      run_q(32'h0000_0007, 32'h0000_0000, 32'h1234_5002,
            stream_table_entry(1'b1, CFG_S2_TRANS, 2'b00, 8'h00, 1'b0, 1'b1));
      chk({30'h0000_0000, res[1:0]}, {30'h0000_0000, RSN_S2_IN});
      chk(wa, 32'h1234_5000);
      run_q(32'h0000_0007, 32'h0000_0000, 32'h5678_9003,
            stream_table_entry(1'b1, CFG_BOTH, DSS_BYPASS, 8'h00, 1'b0, 1'b1));
      chk({30'h0000_0000, res[1:0]}, {30'h0000_0000, RSN_S2_IN});
      chk(wa, 32'h5678_9000);
      run_q(32'h0000_0007, 32'h0000_0000, 32'h5678_9003,
            stream_table_entry(1'b1, CFG_BOTH, DSS_BYPASS, 8'h00, 1'b0, 1'b0));
      chk({12'h000, res[31:12]}, 32'h0005_6789);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      failures = 0;
      check_count = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      sc_reset();
      sc_invocation();
      sc_bypass();
      sc_device_and_fault();
      conclude();
   end
endmodule
